// [core/tsc_defines.vh]
// Constants shared by the time-slot switch control and signalling block
`ifndef TSC_DEFINES_VH
`define TSC_DEFINES_VH

// APB register byte offsets
`define TSC_OFF_MAA       8'h00
`define TSC_OFF_MAD       8'h04
`define TSC_OFF_MAC       8'h08
`define TSC_OFF_EXT_STS   8'h0C
`define TSC_OFF_SIGQ      8'h10
`define TSC_OFF_ARB_EN0   8'h14
`define TSC_OFF_IRQ_STS   8'h18
`define TSC_OFF_IRQ_MASK  8'h1C
`define TSC_OFF_BUSY      8'h20

// Command codes written to the command register
`define TSC_CMD_RD_DATA   4'hC
`define TSC_CMD_WR_DATA   4'h4
`define TSC_CMD_WR_DC     4'h7
`define TSC_CMD_TRI_ALL   8'h68

// Extended status value while the change queue holds entries
`define TSC_EXT_QVALID    8'h40
`define TSC_EXT_NONE      8'h00

// Memory address layout: direction, time slot, port
`define TSC_ADR_DIR       7
`define TSC_DIR_UP        1'b1
`define TSC_DIR_DOWN      1'b0
`define TSC_SLOT_W        5
`define TSC_PORT_W        2
`define TSC_PORT0         2'h0

// Data field layout: four-bit signalling code in bits 5..2, rest ones
`define TSC_CI_HI         5
`define TSC_CI_LO         2
`define TSC_CI_PAD        2'h3
`define TSC_ARB_BIT       4
`define TSC_ARB_AVAIL     1'b0
`define TSC_ARB_SLOT_OFS  2'h2

// Code field and tristate field; tristate bit0 low keeps the slot off the line
`define TSC_CODE_SWITCH   4'h1
`define TSC_CODE_RST      4'h0
`define TSC_DATA_RST      8'hFF
`define TSC_TRI_INIT      4'h0
`define TSC_TRI_HIZ_BIT   0
`define TSC_TRI_IDX_W     5

// Interrupt bits: 0 queue holds entries (level), 1 queue overflow, 2 command done
`define TSC_IRQ_W         3
`define TSC_IRQ_QV        0
`define TSC_IRQ_OVF       1
`define TSC_IRQ_DONE      2
`define TSC_MASK_RST      3'h1

// Signalling change queue depth and arbiter channel count
`define TSC_Q_AW          3
`define TSC_Q_DEPTH       8
`define TSC_NCH           8

`endif

// [core/tsc_sigq.v]
// Signalling change queue: small synchronous FIFO of change entries
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defines.vh"

module tsc_sigq (
  input  wire       clk,     // System clock
  input  wire       rst_n,   // Synchronised reset, active low
  input  wire       clear,   // Drop all entries
  input  wire       push,    // Write one entry
  input  wire [7:0] din,     // Entry to write
  input  wire       pop,     // Remove head entry
  output wire [7:0] dout,    // Head entry
  output wire       empty,   // No entry waiting
  output wire       full     // No room left
);

  reg [7:0]           mem [0:`TSC_Q_DEPTH-1];
  reg [`TSC_Q_AW:0]   wp_q;
  reg [`TSC_Q_AW:0]   rp_q;
  wire                do_push;
  wire                do_pop;

  assign empty   = (wp_q == rp_q);
  assign full    = (wp_q[`TSC_Q_AW] != rp_q[`TSC_Q_AW]) &&
                   (wp_q[`TSC_Q_AW-1:0] == rp_q[`TSC_Q_AW-1:0]);
  assign do_push = push & ~full;
  assign do_pop  = pop & ~empty;
  assign dout    = mem[rp_q[`TSC_Q_AW-1:0]];

  always @(posedge clk)
  begin
    if (do_push)
      mem[wp_q[`TSC_Q_AW-1:0]] <= din;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q <= {(`TSC_Q_AW+1){1'b0}};
      rp_q <= {(`TSC_Q_AW+1){1'b0}};
    end
    else if (clear)
    begin
      wp_q <= {(`TSC_Q_AW+1){1'b0}};
      rp_q <= {(`TSC_Q_AW+1){1'b0}};
    end
    else
    begin
      if (do_push)
        wp_q <= wp_q + 1'b1;
      if (do_pop)
        rp_q <= rp_q + 1'b1;
    end
  end

endmodule
`default_nettype wire

// [core/tsc_top.v]
// Time-slot switch control memory access, signalling changes and arbiter enable
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defines.vh"

// Behaviour
// RULE1 - A changed upstream signalling code queues an entry; extended status reads 40h.
// RULE2 - Each queue entry names direction, time slot and port; 88h is port 0 slot 2.
// RULE3 - Interrupt stays high while entries remain queued; drops when all read.
// RULE4 - Command C8h copies the addressed data field into the data register.
// RULE5 - Command 48h stores the data register into the addressed data field.
// RULE6 - Memory address holds direction bit, time slot and port; 08h down, 88h up.
// RULE7 - Active upstream channel data field reads F3h, carrying code 1100.
// RULE8 - Host confirms activation by writing code 1100 into the downstream field.
// RULE9 - Per-channel arbiter enable register; writing 01h enables channel 0 monitoring.
// RULE10 - Enabling a channel clears its downstream arbitration bit, giving code 1000.
// RULE11 - Command 7xh writes data and code fields; code 1 is 64 kbit/s switching.
// RULE12 - Upstream connection data field names destination PCM port and time slot.
// RULE13 - PCM output stays disabled while the slot's tristate field is high impedance.
// RULE14 - Host waits for each command to finish and reloads the address register.
module tsc_top (
  input  wire        CLK,       // System clock, 25 MHz
  input  wire        RSTN,      // Asynchronous reset, active low
  input  wire        PSEL,      // APB select
  input  wire        PENABLE,   // APB access phase
  input  wire        PWRITE,    // APB write
  input  wire [7:0]  PADDR,     // APB byte address
  input  wire [31:0] PWDATA,    // APB write data
  output reg  [31:0] PRDATA,    // APB read data
  output wire        PREADY,    // APB ready
  output reg         PSLVERR,   // APB error on unmapped address
  output wire        IRQ,       // Interrupt, active high level
  input  wire        CI_VALID,  // Upstream signalling sample present
  output wire        CI_READY,  // Sample taken this cycle
  input  wire [1:0]  CI_PORT,   // Subscriber-side port of sample
  input  wire [4:0]  CI_SLOT,   // Time slot of sample
  input  wire [3:0]  CI_CODE,   // Four-bit signalling code
  input  wire        BU_VALID,  // Upstream B-channel byte present
  input  wire [7:0]  BU_ADDR,   // Upstream memory address of byte
  input  wire [7:0]  BU_DATA,   // B-channel byte
  output reg         PCM_VALID, // Switched byte present
  output reg  [7:0]  PCM_SLOT,  // Destination PCM port and slot
  output reg  [7:0]  PCM_DATA,  // Switched byte
  output reg         PCM_OE,    // Drive PCM line for this byte
  output wire [7:0]  ARB_EN     // Arbiter monitoring enable per channel
);

  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_EXEC = 3'b010;
  localparam [2:0] S_ARB  = 3'b100;

  reg  [1:0]             rst_sync_q;
  wire                   rst_n;
  reg  [2:0]             state_q;
  reg  [2:0]             state_d;
  reg  [7:0]             maa_q;
  reg  [7:0]             mad_q;
  reg  [7:0]             cmd_q;
  reg                    cmd_pend_q;
  reg  [7:0]             arb_en_q;
  reg  [`TSC_NCH-1:0]    arb_pend_q;
  reg  [`TSC_IRQ_W-1:0]  irq_sts_q;
  reg  [`TSC_IRQ_W-1:0]  irq_mask_q;
  reg  [7:0]             conn_data [0:255];
  reg  [3:0]             conn_code [0:255];
  reg  [3:0]             tri_q [0:(1<<`TSC_TRI_IDX_W)-1];
  reg                    mem_we;
  reg  [7:0]             mem_wa;
  reg  [7:0]             mem_wd;
  reg                    mem_wc_we;
  reg  [2:0]             arb_ch;
  reg                    arb_any;
  integer                k;
  wire                   setup_ph;
  wire                   acc_wr;
  wire                   acc_rd;
  wire                   mapped;
  wire [7:0]             ci_addr;
  wire [7:0]             ci_cur;
  wire [7:0]             ci_new;
  wire                   ci_take;
  wire                   ci_change;
  wire                   q_empty;
  wire                   q_full;
  wire [7:0]             q_dout;
  wire                   q_pop;
  wire                   tri_all;
  wire [7:0]             arb_addr;
  wire [7:0]             bu_dest;
  wire [`TSC_IRQ_W-1:0]  ev;
  wire [`TSC_IRQ_W-1:0]  irq_live;

  // Reset released through two flops; assertion still asynchronous
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // APB: zero-wait access, read data captured in the setup cycle
  assign setup_ph = PSEL & ~PENABLE;
  assign PREADY   = 1'b1;
  assign acc_wr   = PSEL & PENABLE & PWRITE;
  assign acc_rd   = PSEL & PENABLE & ~PWRITE;
  assign mapped   = (PADDR == `TSC_OFF_MAA) | (PADDR == `TSC_OFF_MAD) |
                    (PADDR == `TSC_OFF_MAC) | (PADDR == `TSC_OFF_EXT_STS) |
                    (PADDR == `TSC_OFF_SIGQ) | (PADDR == `TSC_OFF_ARB_EN0) |
                    (PADDR == `TSC_OFF_IRQ_STS) | (PADDR == `TSC_OFF_IRQ_MASK) |
                    (PADDR == `TSC_OFF_BUSY);
  assign q_pop    = acc_rd & (PADDR == `TSC_OFF_SIGQ) & ~PSLVERR; // [RULE3]

  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      PRDATA  <= 32'h0;
      PSLVERR <= 1'b0;
    end
    else if (setup_ph)
    begin
      PSLVERR <= ~mapped;
      case (PADDR)
        `TSC_OFF_MAA:      PRDATA <= {24'h0, maa_q};
        `TSC_OFF_MAD:      PRDATA <= {24'h0, mad_q};
        `TSC_OFF_MAC:      PRDATA <= {24'h0, cmd_q};
        `TSC_OFF_EXT_STS:  PRDATA <= {24'h0, q_empty ? `TSC_EXT_NONE : `TSC_EXT_QVALID}; // [RULE1]
        `TSC_OFF_SIGQ:     PRDATA <= {24'h0, q_empty ? 8'h0 : q_dout}; // [RULE2]
        `TSC_OFF_ARB_EN0:  PRDATA <= {24'h0, arb_en_q};
        `TSC_OFF_IRQ_STS:  PRDATA <= {29'h0, irq_live};
        `TSC_OFF_IRQ_MASK: PRDATA <= {29'h0, irq_mask_q};
        `TSC_OFF_BUSY:     PRDATA <= {31'h0, cmd_pend_q};
        default:           PRDATA <= 32'h0;
      endcase
    end
  end

  // Host registers; a command written while one is pending is dropped
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      maa_q      <= 8'h0;
      cmd_q      <= 8'h0;
      cmd_pend_q <= 1'b0;
      arb_en_q   <= 8'h0;
      irq_mask_q <= `TSC_MASK_RST;
    end
    else
    begin
      if (acc_wr && PADDR == `TSC_OFF_MAA)
        maa_q <= PWDATA[7:0];
      if (acc_wr && PADDR == `TSC_OFF_ARB_EN0)
        arb_en_q <= PWDATA[7:0]; // [RULE9]
      if (acc_wr && PADDR == `TSC_OFF_IRQ_MASK)
        irq_mask_q <= PWDATA[`TSC_IRQ_W-1:0];
      if (acc_wr && PADDR == `TSC_OFF_MAC && !cmd_pend_q)
      begin
        cmd_q      <= PWDATA[7:0];
        cmd_pend_q <= 1'b1;
      end
      else if (state_q == S_EXEC)
        cmd_pend_q <= 1'b0;
    end
  end
  assign ARB_EN = arb_en_q;

  // Data register: host writes, read command result overrides in EXEC
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      mad_q <= 8'h0;
    else if (state_q == S_EXEC && cmd_q[7:4] == `TSC_CMD_RD_DATA)
      mad_q <= conn_data[maa_q]; // [RULE4] [RULE7]
    else if (acc_wr && PADDR == `TSC_OFF_MAD)
      mad_q <= PWDATA[7:0];
  end

  // Arbiter pending flag per channel, set on enable rising; set wins
  genvar g;
  generate
    for (g = 0; g < `TSC_NCH; g = g + 1)
    begin : g_arb
      wire rise = acc_wr & (PADDR == `TSC_OFF_ARB_EN0) & PWDATA[g] & ~arb_en_q[g];
      always @(posedge CLK or negedge rst_n)
      begin
        if (!rst_n)
          arb_pend_q[g] <= 1'b0;
        else if (rise)
          arb_pend_q[g] <= 1'b1; // [RULE10]
        else if (state_q == S_ARB && arb_ch == g)
          arb_pend_q[g] <= 1'b0;
      end
    end
  endgenerate

  always @*
  begin
    arb_ch  = 3'h0;
    arb_any = 1'b0;
    for (k = `TSC_NCH - 1; k >= 0; k = k - 1)
    begin
      if (arb_pend_q[k])
      begin
        arb_ch  = k[2:0];
        arb_any = 1'b1;
      end
    end
  end

  // Channel n signalling sits in downstream slot 4n+2 of port 0
  assign arb_addr = {`TSC_DIR_DOWN, arb_ch, `TSC_ARB_SLOT_OFS, `TSC_PORT0}; // [RULE6]

  // Sequencer: host command first, then arbiter, else signalling samples
  always @*
  begin
    state_d = S_IDLE;
    case (state_q)
      S_IDLE:
        if (cmd_pend_q)
          state_d = S_EXEC;
        else if (arb_any)
          state_d = S_ARB;
      S_EXEC:  state_d = S_IDLE;
      S_ARB:   state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= S_IDLE;
    else
      state_q <= state_d;
  end

  // Signalling sample compare against stored upstream field
  assign ci_addr   = {`TSC_DIR_UP, CI_SLOT, CI_PORT}; // [RULE6]
  assign ci_cur    = conn_data[ci_addr];
  assign ci_new    = {`TSC_CI_PAD, CI_CODE, `TSC_CI_PAD}; // [RULE7]
  assign CI_READY  = (state_q == S_IDLE) & ~cmd_pend_q & ~arb_any;
  assign ci_take   = CI_VALID & CI_READY;
  assign ci_change = ci_take & (ci_cur[`TSC_CI_HI:`TSC_CI_LO] != CI_CODE); // [RULE1]
  assign tri_all   = (state_q == S_EXEC) & (cmd_q == `TSC_CMD_TRI_ALL);

  // Single write port into the connection memory
  always @*
  begin
    mem_we    = 1'b0;
    mem_wa    = maa_q;
    mem_wd    = mad_q;
    mem_wc_we = 1'b0;
    case (state_q)
      S_EXEC:
      begin
        if (cmd_q[7:4] == `TSC_CMD_WR_DATA)
          mem_we = 1'b1; // [RULE5]
        else if (cmd_q[7:4] == `TSC_CMD_WR_DC)
        begin
          mem_we    = 1'b1; // [RULE11]
          mem_wc_we = 1'b1;
        end
      end
      S_ARB:
      begin
        mem_we = 1'b1;
        mem_wa = arb_addr;
        mem_wd = conn_data[arb_addr];
        mem_wd[`TSC_ARB_BIT] = `TSC_ARB_AVAIL; // [RULE10]
      end
      default:
      begin
        mem_we = ci_change;
        mem_wa = ci_addr;
        mem_wd = ci_new;
      end
    endcase
  end

  // Memory contents are cleared only by software initialisation
  always @(posedge CLK)
  begin
    if (mem_we)
      conn_data[mem_wa] <= mem_wd;
    if (mem_wc_we)
      conn_code[mem_wa] <= cmd_q[3:0]; // [RULE11]
  end

  // Tristate memory per PCM slot, high impedance from reset
  generate
    for (g = 0; g < (1 << `TSC_TRI_IDX_W); g = g + 1)
    begin : g_tri
      always @(posedge CLK or negedge rst_n)
      begin
        if (!rst_n)
          tri_q[g] <= `TSC_TRI_INIT; // [RULE13]
        else if (tri_all)
          tri_q[g] <= mad_q[3:0];
      end
    end
  endgenerate

  // Upstream switching toward PCM; one cycle of latency
  assign bu_dest = conn_data[BU_ADDR]; // [RULE12]
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      PCM_VALID <= 1'b0;
      PCM_SLOT  <= 8'h0;
      PCM_DATA  <= 8'h0;
      PCM_OE    <= 1'b0;
    end
    else
    begin
      PCM_VALID <= BU_VALID & BU_ADDR[`TSC_ADR_DIR] &
                   (conn_code[BU_ADDR] == `TSC_CODE_SWITCH); // [RULE11]
      PCM_SLOT  <= bu_dest;
      PCM_DATA  <= BU_DATA;
      // A cleared tristate bit means high impedance, so a fresh slot stays off
      PCM_OE    <= BU_VALID & BU_ADDR[`TSC_ADR_DIR] &
                   (conn_code[BU_ADDR] == `TSC_CODE_SWITCH) &
                   tri_q[bu_dest[`TSC_TRI_IDX_W-1:0]][`TSC_TRI_HIZ_BIT]; // [RULE13]
    end
  end

  // Change queue; entry is the upstream address of the changed slot
  tsc_sigq u_sigq (
    .clk   (CLK),
    .rst_n (rst_n),
    .clear (1'b0),
    .push  (ci_change), // [RULE1] [RULE2]
    .din   (ci_addr),
    .pop   (q_pop),
    .dout  (q_dout),
    .empty (q_empty),
    .full  (q_full)
  );

  // Sticky events, cleared by writing one; a new event beats the clear
  assign ev = {(state_q == S_EXEC), ci_change & q_full, 1'b0};
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      irq_sts_q <= {`TSC_IRQ_W{1'b0}};
    else
      irq_sts_q <= ev | (irq_sts_q &
                   ~((acc_wr && PADDR == `TSC_OFF_IRQ_STS) ?
                     PWDATA[`TSC_IRQ_W-1:0] : {`TSC_IRQ_W{1'b0}}));
  end

  // Queue bit is a level so the line drops once the queue is drained
  assign irq_live = {irq_sts_q[`TSC_IRQ_W-1:1], ~q_empty}; // [RULE3]
  assign IRQ      = |(irq_live & irq_mask_q); // [RULE3]

endmodule
`default_nettype wire

// [verification/tsc_sub_model.sv]
// Subscriber transceiver model reporting upstream signalling samples
`timescale 1ns/1ps
`default_nettype none
module tsc_sub_model (
  input  wire logic       clk,      // System clock
  input  wire logic       go,       // Start one sample
  input  wire logic [4:0] slot,     // Slot to report
  input  wire logic [3:0] code,     // Code to report
  input  wire logic       ci_ready, // Device took sample
  output logic            ci_valid, // Sample present
  output logic [1:0]      ci_port,  // Driven port
  output logic [4:0]      ci_slot,  // Driven slot
  output logic [3:0]      ci_code   // Driven code
);
  initial
  begin
    ci_valid = 1'b0;
    ci_port = 2'h0;
    ci_slot = 5'h00;
    ci_code = 4'h0;
  end
  // Sample held until taken, then fields scrambled so stale values never match
  always @(posedge clk)
    if (go)
    begin
      ci_valid <= 1'b1;
      ci_port <= 2'h0;
      ci_slot <= slot;
      ci_code <= code;
    end
    else if (ci_valid && ci_ready)
    begin
      ci_valid <= 1'b0;
      ci_port <= ~ci_port;
      ci_slot <= ~ci_slot;
      ci_code <= ~ci_code;
    end
endmodule
`default_nettype wire

// [verification/tsc_top_properties.sv]
// Concurrent checks on the control and signalling block ports
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defines.vh"
module tsc_top_properties (
  input wire logic        CLK,       // System clock
  input wire logic        RSTN,      // Reset, active low
  input wire logic        PSEL,      // APB select
  input wire logic        PENABLE,   // APB access phase
  input wire logic        PWRITE,    // APB write
  input wire logic [7:0]  PADDR,     // APB address
  input wire logic [31:0] PWDATA,    // APB write data
  input wire logic [31:0] PRDATA,    // APB read data
  input wire logic        PREADY,    // APB ready
  input wire logic        CI_READY,  // Sample taken
  input wire logic        BU_VALID,  // B-channel byte present
  input wire logic [7:0]  BU_ADDR,   // Source address
  input wire logic [7:0]  BU_DATA,   // Source byte
  input wire logic        PCM_VALID, // Switched byte
  input wire logic [7:0]  PCM_DATA,  // Switched data
  input wire logic        PCM_OE,    // PCM drive
  input wire logic [7:0]  ARB_EN,    // Arbiter enable
  input wire logic        IRQ        // Interrupt
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  wire acc = PSEL && PENABLE && PREADY;

  a_ready_high: assert property (PREADY) else $error("ready low");
  a_oe_needs_valid: assert property (PCM_OE |-> PCM_VALID) else $error("oe alone");
  a_pcm_source: assert property (PCM_VALID |-> $past(BU_VALID) && $past(BU_ADDR[7]))
    else $error("pcm byte without upstream source");
  a_pcm_data_copy: assert property (PCM_VALID |-> PCM_DATA == $past(BU_DATA))
    else $error("pcm byte differs");
  a_arb_en_load: assert property (acc && PWRITE && PADDR == `TSC_OFF_ARB_EN0
    |=> ARB_EN == $past(PWDATA[7:0])) else $error("arbiter enable not loaded");
  a_ext_status_value: assert property (acc && !PWRITE && PADDR == `TSC_OFF_EXT_STS
    |-> PRDATA == 32'h40 || PRDATA == 32'h0) else $error("bad extended status");
  a_cmd_stalls_ci: assert property (acc && PWRITE && PADDR == `TSC_OFF_MAC
    |=> !CI_READY) else $error("samples taken during command");
  a_queue_upper_zero: assert property (acc && !PWRITE && PADDR == `TSC_OFF_SIGQ
    |-> PRDATA[31:8] == 24'h0) else $error("queue entry too wide");

  c_irq_rise: cover property ($rose(IRQ));
  c_pcm_drive: cover property (PCM_OE);
  c_arb_on: cover property (ARB_EN[0]);
endmodule

bind tsc_top tsc_top_properties i_props (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .CI_READY(CI_READY), .BU_VALID(BU_VALID), .BU_ADDR(BU_ADDR),
  .BU_DATA(BU_DATA), .PCM_VALID(PCM_VALID), .PCM_DATA(PCM_DATA), .PCM_OE(PCM_OE),
  .ARB_EN(ARB_EN), .IRQ(IRQ));
`default_nettype wire

// [verification/tsc_top_test.sv]
// Self-checking bench for the control and signalling block
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defines.vh"
module tsc_top_test;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        bu_valid = 1'b0;
  logic [7:0]  bu_addr = 8'h00;
  logic [7:0]  bu_data = 8'h00;
  logic        go = 1'b0;
  logic [4:0]  g_slot = 5'h00;
  logic [3:0]  g_code = 4'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq, ci_valid, ci_ready, pcm_valid, pcm_oe;
  wire  [1:0]  ci_port;
  wire  [4:0]  ci_slot;
  wire  [3:0]  ci_code;
  wire  [7:0]  pcm_slot, pcm_data, arb_en;
  int          fails = 0;
  int          total_checks = 0;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  b;
  logic [7:0]  conn [256];
  logic [7:0]  q [$];

  always #20 clk = ~clk;

  tsc_top i_dut (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .IRQ(irq), .CI_VALID(ci_valid), .CI_READY(ci_ready), .CI_PORT(ci_port),
    .CI_SLOT(ci_slot), .CI_CODE(ci_code), .BU_VALID(bu_valid), .BU_ADDR(bu_addr),
    .BU_DATA(bu_data), .PCM_VALID(pcm_valid), .PCM_SLOT(pcm_slot), .PCM_DATA(pcm_data),
    .PCM_OE(pcm_oe), .ARB_EN(arb_en));

  tsc_sub_model i_sub (.clk(clk), .go(go), .slot(g_slot), .code(g_code),
    .ci_ready(ci_ready), .ci_valid(ci_valid), .ci_port(ci_port), .ci_slot(ci_slot),
    .ci_code(ci_code));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No wait count assumed; only the watchdog ends a stalled access
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Full indirect command; waits for busy to clear before the next one
  task automatic cmd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
    int n;
    n = 0;
    apb(1'b1, `TSC_OFF_MAA, {24'h0, a});
    apb(1'b1, `TSC_OFF_MAD, {24'h0, d});
    apb(1'b1, `TSC_OFF_MAC, {24'h0, c});
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 20)
    begin
      apb(1'b0, `TSC_OFF_BUSY, 32'h0);
      n++;
    end
    if (n == 20)
      fails++;
    if (c[7:4] == 4'h4 || c[7:4] == 4'h7)
      conn[a] = d;
  endtask

  task automatic rdcm(input logic [7:0] a);
    cmd(a, 8'h00, 8'hC8);
    apb(1'b0, `TSC_OFF_MAD, 32'h0);
  endtask

  task automatic ci(input logic [4:0] s, input logic [3:0] c);
    int n;
    logic [7:0] a;
    n = 0;
    a = {1'b1, s, 2'b00};
    @(posedge clk);
    go <= 1'b1;
    g_slot <= s;
    g_code <= c;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (ci_valid !== 1'b0 && n < 50)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 50)
      fails++;
    if (conn[a][5:2] != c)
    begin
      q.push_back(a);
      conn[a] = {2'b11, c, 2'b11};
    end
  endtask

  task automatic bu(input logic [7:0] a, input logic v, input logic oe);
    b = $urandom;
    @(posedge clk);
    bu_valid <= 1'b1;
    bu_addr <= a;
    bu_data <= b;
    @(posedge clk);
    bu_valid <= 1'b0;
    // PCM_VALID and PCM_OE stand for one cycle only; look mid-cycle, away from both edges
    @(negedge clk);
    chk(pcm_valid, v);
    if (v)
    begin
      chk(pcm_slot, conn[a]);
      chk(pcm_data, b);
      chk(pcm_oe, oe);
    end
  endtask

  initial
  begin
    b = $urandom(32'h6035);
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, `TSC_OFF_ARB_EN0, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `TSC_OFF_IRQ_MASK, 32'h0);
    chk(rd, {29'h0, `TSC_MASK_RST});
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("test 1 done");
    cmd(8'h88, 8'hFF, 8'h70);
    cmd(8'h08, 8'hFF, 8'h70);
    rdcm(8'h88);
    chk(rd, conn[8'h88]);
    $display("test 2 done");
    repeat (2)
    begin
      b = $urandom;
      ci(5'h02, b[3:0]);
    end
    ci(5'h02, 4'hC);
    @(posedge clk);
    chk(irq, q.size() != 0);
    apb(1'b0, `TSC_OFF_EXT_STS, 32'h0);
    chk(rd, 32'h40);
    apb(1'b1, `TSC_OFF_IRQ_MASK, 32'h0);
    @(posedge clk);
    chk(irq, 1'b0);
    apb(1'b1, `TSC_OFF_IRQ_MASK, 32'h1);
    while (q.size() != 0)
    begin
      apb(1'b0, `TSC_OFF_SIGQ, 32'h0);
      chk(rd, q.pop_front());
      @(posedge clk);
      chk(irq, q.size() != 0);
    end
    apb(1'b0, `TSC_OFF_EXT_STS, 32'h0);
    chk(rd, 32'h0);
    rdcm(8'h88);
    chk(rd, 32'hF3);
    rdcm(8'h08);
    chk(rd, 32'hFF);
    $display("test 3 done");
    cmd(8'h08, 8'hF3, 8'h48);
    rdcm(8'h08);
    chk(rd, conn[8'h08]);
    apb(1'b1, `TSC_OFF_ARB_EN0, 32'h1);
    @(posedge clk);
    chk(arb_en, 8'h01);
    repeat (4) @(posedge clk);
    rdcm(8'h08);
    chk(rd, 32'hE3);
    $display("test 4 done");
    cmd(8'h80, 8'h81, 8'h71);
    cmd(8'h00, 8'hF0, `TSC_CMD_TRI_ALL);
    bu(8'h80, 1'b1, 1'b0);
    bu(8'h08, 1'b0, 1'b0);
    cmd(8'h00, 8'h0F, `TSC_CMD_TRI_ALL);
    bu(8'h80, 1'b1, 1'b1);
    $display("test 5 done");
    apb(1'b1, `TSC_OFF_IRQ_MASK, 32'h4);
    @(posedge clk);
    chk(irq, 1'b1);
    apb(1'b1, `TSC_OFF_IRQ_STS, 32'h4);
    @(posedge clk);
    chk(irq, 1'b0);
    $display("test 6 done");
    stop_test();
  end

  // Whole run needs a few hundred cycles at most
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test();
  end
endmodule
`default_nettype wire
